// file: cfgdec_pkg.sv
// constants, field layout, encodings and state for the configuration decoder
// assumes a single 200 mhz core clock; configuration words are 8 bits wide
package cfgdec_pkg;
    // clock and timing
    localparam int CLK_HZ = 200_000_000;
    localparam int US_PER_S = 1_000_000;
    localparam int US_CYCLES_DEF = CLK_HZ / US_PER_S;
    localparam int REG_STARTUP_US = 20;
    localparam int POWERUP_TIMER_BASE_MS = 2;
    localparam int US_PER_MS = 1000;
    localparam int FAILSAFE_US = 100;
    localparam int WAIT_W = 17;
    localparam int DIV_W = 16;
    // configuration word addresses in configuration space
    localparam logic [23:0] ADDR_SECURE = 24'hf80002;
    localparam logic [23:0] ADDR_GENERAL = 24'hf80004;
    localparam logic [23:0] ADDR_OSC_SEL = 24'hf80006;
    localparam logic [23:0] ADDR_OSC_MODE = 24'hf80008;
    localparam logic [23:0] ADDR_WATCHDOG = 24'hf8000a;
    localparam logic [23:0] ADDR_POWER_ON = 24'hf8000c;
    localparam logic [23:0] ADDR_DEBUG = 24'hf8000e;
    // implemented bits; erased value is every implemented bit at one
    localparam logic [7:0] MASK_SECURE = 8'hcf;
    localparam logic [7:0] MASK_GENERAL = 8'h07;
    localparam logic [7:0] MASK_OSC_SEL = 8'h87;
    localparam logic [7:0] MASK_OSC_MODE = 8'hc7;
    localparam logic [7:0] MASK_WATCHDOG = 8'hff;
    localparam logic [7:0] MASK_POWER_ON = 8'h07;
    localparam logic [7:0] MASK_DEBUG = 8'he3;
    // field positions
    localparam int SEC_WLOCK_BIT = 0;
    localparam int SEC_SIZE_LSB = 1;
    localparam int SEC_RAM_LSB = 6;
    localparam int GEN_WLOCK_BIT = 0;
    localparam int GEN_PROT_LSB = 1;
    localparam int OSC_SEL_LSB = 0;
    localparam int TWO_SPEED_BIT = 7;
    localparam int PRI_MODE_LSB = 0;
    localparam int OSC_PIN_BIT = 2;
    localparam int SWITCH_MODE_LSB = 6;
    localparam int WD_POST_LSB = 0;
    localparam int WD_PRE_BIT = 4;
    localparam int PLL_WAIT_BIT = 5;
    localparam int WD_WINDOW_BIT = 6;
    localparam int WD_FORCE_BIT = 7;
    localparam int POWERUP_TIMER_LSB = 0;
    localparam int DEBUG_CH_LSB = 0;
    localparam int SCAN_EN_BIT = 5;
    // oscillator source and primary mode codes
    localparam logic [2:0] OSC_FRC = 3'h0;
    localparam logic [2:0] OSC_FRC_PLL = 3'h1;
    localparam logic [2:0] OSC_PRI = 3'h2;
    localparam logic [2:0] OSC_PRI_PLL = 3'h3;
    localparam logic [2:0] OSC_SEC = 3'h4;
    localparam logic [2:0] OSC_LOW_POWER_RC = 3'h5;
    localparam logic [2:0] OSC_RSVD = 3'h6;
    localparam logic [2:0] OSC_FRC_DIV = 3'h7;
    localparam logic [1:0] PRI_EC = 2'h0;
    localparam logic [1:0] PRI_XT = 2'h1;
    localparam logic [1:0] PRI_HS = 2'h2;
    localparam logic [1:0] PRI_OFF = 2'h3;
    // segment ends, ram sizes and watchdog prescaler exponents
    localparam logic [23:0] SEG_END_A = 24'h001ffe;
    localparam logic [23:0] SEG_END_B = 24'h003ffe;
    localparam logic [23:0] SEG_END_C = 24'h007ffe;
    localparam logic [23:0] SEG_END_D = 24'h00fffe;
    localparam logic [23:0] SEG_STEP = 24'h000002;
    localparam logic [12:0] SRAM_SMALL = 13'd256;
    localparam logic [12:0] SRAM_MID = 13'd2048;
    localparam logic [12:0] SRAM_BIG = 13'd4096;
    localparam logic [3:0] WD_PRE_LO = 4'd5;
    localparam logic [3:0] WD_PRE_HI = 4'd7;

    typedef enum logic [1:0] {
        SEQ_REG = 2'b00,
        SEQ_HOLD = 2'b01,
        SEQ_RUN = 2'b11
    } seq_e;

    typedef struct packed {
        logic [7:0] secure;
        logic [7:0] general;
        logic [7:0] osc_sel;
        logic [7:0] osc_mode;
        logic [7:0] watchdog;
        logic [7:0] power_on;
        logic [7:0] debug;
        logic [7:0] rdata;
        logic [2:0] osc_eff;
        seq_e seq;
        logic [DIV_W-1:0] div;
        logic [WAIT_W-1:0] wait_cnt;
        logic bor_flag;
        logic [3:0] sync1;
        logic [3:0] sync2;
        logic bor_prev;
        logic por_prev;
    } state_s;
endpackage

// file: config_decode_reset_seq.sv
// configuration word store, field decoder and reset release sequencer
// assumes one core clock; power and oscillator status arrive asynchronously
// Contract
// R1 - large parts: secure size codes end segment
// R2 - small parts: secure size codes, smaller ends
// R3 - secure ram size less boot ram
// R4 - general protect: none, standard, high security
// R5 - general write lock zero blocks writes
// R6 - two-speed start on fast rc, then switch
// R7 - initial oscillator field selects source
// R8 - with switching on, source change waits reset
// R9 - switch mode enables switching and monitor
// R10 - second pin outputs clock outside crystal modes
// R11 - primary mode: off, hs, xt, ec
// R12 - watchdog forced on overrides software enable
// R13 - window off bit selects watchdog mode
// R14 - pll switch waits lock when enabled
// R15 - prescaler 1:128 or 1:32
// R16 - postscaler power-of-two up to 1:32768
// R17 - power-up delay doubles from 2 ms
// R18 - scan enable and debug pair select
// R19 - regulator start-up hold after power-up
// R20 - brown-out resets, waits oscillator and lock
// R21 - power-up delay concurrent, failsafe delay otherwise
// R22 - brown-out sets status flag bit one
// R23 - programmed bits read zero, erased one
// R24 - startup source captured during reset
`timescale 1ns/100ps
`default_nettype none
module config_decode_reset_seq #(
    parameter int US_CYCLES = cfgdec_pkg::US_CYCLES_DEF,
    parameter bit LARGE_PART = 1'b1
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic reset_in,
    // configuration table access
    input wire logic [23:0] cfg_addr_in,
    input wire logic cfg_rd_in,
    input wire logic cfg_wr_in,
    input wire logic [7:0] cfg_wdata_in,
    output logic [7:0] cfg_rdata_out,
    // boot segment context
    input wire logic [23:0] boot_end_in,
    input wire logic [12:0] boot_ram_bytes_in,
    // asynchronous power and oscillator status
    input wire logic power_up_in,
    input wire logic brownout_in,
    input wire logic osc_ready_in,
    input wire logic pll_lock_in,
    // core side controls
    input wire logic watchdog_soft_enable_in,
    input wire logic bor_flag_clear_in,
    input wire logic switch_req_in,
    input wire logic [2:0] switch_target_in,
    // reset sequencing and clock switch go
    output logic core_reset_out,
    output logic exec_hold_out,
    output logic sysclk_hold_out,
    output logic brownout_flag_out,
    output logic switch_go_out,
    // decoded memory protection
    output logic secure_present_out,
    output logic secure_high_out,
    output logic [23:0] secure_start_out,
    output logic [23:0] secure_end_out,
    output logic secure_write_block_out,
    output logic [12:0] secure_ram_bytes_out,
    output logic general_protect_out,
    output logic general_high_out,
    output logic [23:0] general_start_out,
    output logic general_write_lock_out,
    // decoded clocking
    output logic [2:0] active_osc_out,
    output logic [2:0] initial_osc_sel_out,
    output logic clock_switch_en_out,
    output logic failsafe_en_out,
    output logic [1:0] primary_osc_mode_out,
    output logic osc_pin_clock_out,
    // decoded watchdog, power-up delay and debug
    output logic watchdog_run_out,
    output logic watchdog_window_out,
    output logic [3:0] watchdog_pre_log2_out,
    output logic [3:0] watchdog_post_log2_out,
    output logic [7:0] powerup_delay_ms_out,
    output logic boundary_scan_enable_out,
    output logic [1:0] debug_pair_out
);
    import cfgdec_pkg::*;

    localparam int US_W = US_CYCLES - 1;
    localparam logic [DIV_W-1:0] US_LAST = US_W[DIV_W-1:0];
    localparam logic [WAIT_W-1:0] REG_WAIT = REG_STARTUP_US[WAIT_W-1:0];
    localparam logic [WAIT_W-1:0] FSCM_WAIT = FAILSAFE_US[WAIT_W-1:0];
    localparam int POWERUP_TIMER_BASE_US = POWERUP_TIMER_BASE_MS * US_PER_MS;
    localparam logic [WAIT_W-1:0] POWERUP_TIMER_UNIT = POWERUP_TIMER_BASE_US[WAIT_W-1:0];
    localparam logic [7:0] POWERUP_TIMER_MS_UNIT = POWERUP_TIMER_BASE_MS[7:0];
    localparam state_s RESET_ST = '{
        secure: MASK_SECURE,
        general: MASK_GENERAL,
        osc_sel: MASK_OSC_SEL,
        osc_mode: MASK_OSC_MODE,
        watchdog: MASK_WATCHDOG,
        power_on: MASK_POWER_ON,
        debug: MASK_DEBUG,
        rdata: 8'h00,
        osc_eff: OSC_FRC_DIV,
        seq: SEQ_REG,
        div: '0,
        wait_cnt: REG_WAIT,
        bor_flag: 1'b0,
        sync1: 4'h0,
        sync2: 4'h0,
        bor_prev: 1'b0,
        por_prev: 1'b0
    };

    state_s st;
    state_s next_st;

    // synchronised status
    logic por_s;
    logic bor_s;
    logic ready_s;
    logic lock_s;
    assign {lock_s, ready_s, bor_s, por_s} = st.sync2;

    // field views
    logic [2:0] sss;
    logic [1:0] rss;
    logic [1:0] gss;
    logic [2:0] osc_live;
    logic [1:0] pri_mode;
    logic [1:0] sw_mode;
    logic [2:0] powerup_timer_sel;
    logic [1:0] ics;
    assign sss = st.secure[SEC_SIZE_LSB +: 3];
    assign rss = st.secure[SEC_RAM_LSB +: 2];
    assign gss = st.general[GEN_PROT_LSB +: 2];
    assign osc_live = st.osc_sel[OSC_SEL_LSB +: 3];
    assign pri_mode = st.osc_mode[PRI_MODE_LSB +: 2];
    assign sw_mode = st.osc_mode[SWITCH_MODE_LSB +: 2];
    assign powerup_timer_sel = st.power_on[POWERUP_TIMER_LSB +: 3];
    assign ics = st.debug[DEBUG_CH_LSB +: 2];

    // decoded helpers
    logic sec_on;
    logic crystal;
    logic osc_mode_used;
    logic pll_used;
    logic clock_ok;
    logic [WAIT_W-1:0] hold_wait;
    logic tick;
    logic bor_rise;
    logic por_rise;
    logic [23:0] sec_end;
    logic [12:0] sram;

    // bits programmed read zero, erased read one; the field decode uses them as is [R23]
    assign sec_on = (sss[1:0] != 2'b11);
    always_comb begin
        unique case (sss[1:0])
            2'b10: sec_end = LARGE_PART ? SEG_END_B : SEG_END_A; // [R1] [R2]
            2'b01: sec_end = LARGE_PART ? SEG_END_C : SEG_END_B; // [R1] [R2]
            2'b00: sec_end = LARGE_PART ? SEG_END_D : SEG_END_C; // [R1] [R2]
            default: sec_end = boot_end_in;
        endcase
    end
    always_comb begin
        case (rss)
            2'b10: sram = SRAM_SMALL - boot_ram_bytes_in; // [R3]
            2'b01: sram = SRAM_MID - boot_ram_bytes_in; // [R3]
            2'b00: sram = SRAM_BIG - boot_ram_bytes_in; // [R3]
            default: sram = 13'h0000;
        endcase
    end

    assign crystal = (pri_mode == PRI_XT) || (pri_mode == PRI_HS);
    assign osc_mode_used = ((st.osc_eff == OSC_PRI || st.osc_eff == OSC_PRI_PLL)
        && pri_mode != PRI_OFF) || (st.osc_eff == OSC_SEC);
    assign pll_used = (st.osc_eff == OSC_PRI_PLL) || (st.osc_eff == OSC_FRC_PLL);
    // oscillator start-up must expire, and lock must be seen, before the clock runs
    assign clock_ok = (!osc_mode_used || ready_s) && (!pll_used || lock_s); // [R20]

    // delay in microsecond ticks; zero power-up delay with a crystal uses the failsafe delay
    always_comb begin
        if (powerup_timer_sel != 3'h0) begin
            hold_wait = POWERUP_TIMER_UNIT << (powerup_timer_sel - 3'h1); // [R17] [R21]
        end else if (crystal) begin
            hold_wait = FSCM_WAIT; // [R21]
        end else begin
            hold_wait = '0;
        end
    end

    assign tick = (st.div == US_LAST);
    assign por_rise = por_s && !st.por_prev;
    assign bor_rise = bor_s && !st.bor_prev;

    always_comb begin
        next_st = st;
        next_st.sync1 = {pll_lock_in, osc_ready_in, brownout_in, power_up_in};
        next_st.sync2 = st.sync1;
        next_st.por_prev = por_s;
        next_st.bor_prev = bor_s;
        next_st.div = tick ? '0 : st.div + 1'b1;
        // table access: only implemented bits store, unmapped reads give zero
        next_st.rdata = st.rdata;
        if (cfg_rd_in) begin
            case (cfg_addr_in)
                ADDR_SECURE: next_st.rdata = st.secure;
                ADDR_GENERAL: next_st.rdata = st.general;
                ADDR_OSC_SEL: next_st.rdata = st.osc_sel;
                ADDR_OSC_MODE: next_st.rdata = st.osc_mode;
                ADDR_WATCHDOG: next_st.rdata = st.watchdog;
                ADDR_POWER_ON: next_st.rdata = st.power_on;
                ADDR_DEBUG: next_st.rdata = st.debug;
                default: next_st.rdata = 8'h00;
            endcase
        end
        if (cfg_wr_in) begin
            case (cfg_addr_in)
                ADDR_SECURE: next_st.secure = cfg_wdata_in & MASK_SECURE;
                ADDR_GENERAL: next_st.general = cfg_wdata_in & MASK_GENERAL;
                ADDR_OSC_SEL: next_st.osc_sel = cfg_wdata_in & MASK_OSC_SEL;
                ADDR_OSC_MODE: next_st.osc_mode = cfg_wdata_in & MASK_OSC_MODE;
                ADDR_WATCHDOG: next_st.watchdog = cfg_wdata_in & MASK_WATCHDOG;
                ADDR_POWER_ON: next_st.power_on = cfg_wdata_in & MASK_POWER_ON;
                ADDR_DEBUG: next_st.debug = cfg_wdata_in & MASK_DEBUG;
                default: next_st.debug = st.debug;
            endcase
        end
        // source follows the field while held in reset or while switching is off
        if (st.seq != SEQ_RUN || sw_mode[1]) begin
            next_st.osc_eff = osc_live; // [R8] [R24]
        end
        // status flag: a new brown-out wins over a clear in the same cycle
        if (bor_flag_clear_in) begin
            next_st.bor_flag = 1'b0;
        end
        if (bor_rise) begin
            next_st.bor_flag = 1'b1; // [R22]
        end
        case (st.seq)
            SEQ_REG: begin
                if (st.wait_cnt == '0) begin
                    next_st.seq = SEQ_HOLD;
                    next_st.wait_cnt = hold_wait; // [R21]
                end else if (tick) begin
                    next_st.wait_cnt = st.wait_cnt - 1'b1; // [R19]
                end
            end
            SEQ_HOLD: begin
                if (st.wait_cnt != '0) begin
                    if (tick) begin
                        next_st.wait_cnt = st.wait_cnt - 1'b1; // [R21]
                    end
                end else if (clock_ok) begin
                    next_st.seq = SEQ_RUN; // [R20]
                end
            end
            SEQ_RUN: next_st.wait_cnt = '0;
            default: next_st.seq = SEQ_REG;
        endcase
        // brown-out is watched in every sequencer state, run included
        if (bor_rise) begin
            next_st.seq = SEQ_HOLD; // [R20] [R22]
            next_st.wait_cnt = hold_wait;
            next_st.osc_eff = osc_live; // [R20]
        end
        if (por_rise) begin
            next_st.seq = SEQ_REG; // [R19]
            next_st.wait_cnt = REG_WAIT;
            next_st.osc_eff = osc_live;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            st <= RESET_ST;
        end else begin
            st <= next_st;
        end
    end

    // sequencing outputs
    assign cfg_rdata_out = st.rdata;
    assign core_reset_out = (st.seq != SEQ_RUN);
    assign exec_hold_out = (st.seq == SEQ_REG); // [R19]
    assign sysclk_hold_out = (st.seq == SEQ_HOLD) && !clock_ok; // [R20]
    assign brownout_flag_out = st.bor_flag; // [R22]
    // switch to a pll source stalls on lock only when asked to
    assign switch_go_out = switch_req_in && clock_switch_en_out
        && !((switch_target_in == OSC_PRI_PLL || switch_target_in == OSC_FRC_PLL)
        && st.watchdog[PLL_WAIT_BIT] && !lock_s); // [R14]

    // memory protection
    assign secure_present_out = sec_on; // [R1] [R2]
    assign secure_high_out = sec_on && !sss[2]; // [R1]
    assign secure_start_out = boot_end_in + SEG_STEP; // [R2]
    assign secure_end_out = sec_end;
    assign secure_write_block_out = !st.secure[SEC_WLOCK_BIT];
    assign secure_ram_bytes_out = sram;
    assign general_protect_out = (gss != 2'b11); // [R4]
    assign general_high_out = !gss[1]; // [R4]
    assign general_start_out = sec_end + SEG_STEP; // [R4]
    assign general_write_lock_out = !st.general[GEN_WLOCK_BIT]; // [R5]

    // clocking; with two-speed start the fast rc runs until the source is ready
    always_comb begin
        if (st.osc_sel[TWO_SPEED_BIT] && osc_mode_used && !ready_s) begin
            active_osc_out = OSC_FRC; // [R6]
        end else if (st.osc_eff == OSC_RSVD) begin
            active_osc_out = OSC_FRC; // reserved code falls back to a safe source
        end else begin
            active_osc_out = st.osc_eff; // [R7]
        end
    end
    assign initial_osc_sel_out = osc_live; // [R7]
    assign clock_switch_en_out = !sw_mode[1]; // [R9]
    assign failsafe_en_out = (sw_mode == 2'b00); // [R9]
    assign primary_osc_mode_out = pri_mode; // [R11]
    assign osc_pin_clock_out = !crystal && st.osc_mode[OSC_PIN_BIT]; // [R10]

    // watchdog, power-up delay and debug
    assign watchdog_run_out = st.watchdog[WD_FORCE_BIT] || watchdog_soft_enable_in; // [R12]
    assign watchdog_window_out = !st.watchdog[WD_WINDOW_BIT]; // [R13]
    assign watchdog_pre_log2_out = st.watchdog[WD_PRE_BIT] ? WD_PRE_HI : WD_PRE_LO; // [R15]
    assign watchdog_post_log2_out = st.watchdog[WD_POST_LSB +: 4]; // [R16]
    assign powerup_delay_ms_out = (powerup_timer_sel == 3'h0) ? 8'h00
        : POWERUP_TIMER_MS_UNIT << (powerup_timer_sel - 3'h1); // [R17]
    assign boundary_scan_enable_out = st.debug[SCAN_EN_BIT]; // [R18]
    assign debug_pair_out = ~ics; // [R18]
endmodule
`default_nettype wire

// file: config_decode_reset_seq_chk.sv
// assertion checker for the configuration decoder and reset sequencer
// assumes cfgdec_pkg is compiled first; bound to every design instance
`timescale 1ns/100ps
`default_nettype none
module config_decode_reset_seq_chk
    import cfgdec_pkg::*;
#(
    parameter int US_CYCLES = 4,
    parameter bit LARGE_PART = 1'b1
) (
    // clock, reset and table writes
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire logic [23:0] cfg_addr_in,
    input wire logic cfg_wr_in,
    input wire logic [7:0] cfg_wdata_in,
    // power events
    input wire logic power_up_in,
    input wire logic brownout_in,
    // watched outputs
    input wire logic core_reset_out,
    input wire logic exec_hold_out,
    input wire logic sysclk_hold_out,
    input wire logic brownout_flag_out,
    input wire logic general_write_lock_out,
    input wire logic clock_switch_en_out,
    input wire logic failsafe_en_out,
    input wire logic [1:0] primary_osc_mode_out,
    input wire logic watchdog_window_out,
    input wire logic [3:0] watchdog_pre_log2_out,
    input wire logic [3:0] watchdog_post_log2_out,
    input wire logic [7:0] powerup_delay_ms_out,
    input wire logic boundary_scan_enable_out,
    input wire logic [1:0] debug_pair_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (reset_in);
    sequence wr_at(logic [23:0] a);
        cfg_wr_in && cfg_addr_in == a;
    endsequence
    // events pass a synchroniser, so only a short window is allowed
    sequence bor_rise;
        $rose(brownout_in) && !power_up_in ##1 brownout_in;
    endsequence
    sequence pu_rise;
        $rose(power_up_in);
    endsequence
    write_lock_a: assert property (wr_at(ADDR_GENERAL) |=>
        general_write_lock_out == !$past(cfg_wdata_in[0])) else $error("write lock decode");
    switch_mode_a: assert property (wr_at(ADDR_OSC_MODE) |=>
        clock_switch_en_out == !$past(cfg_wdata_in[7])
        && failsafe_en_out == ($past(cfg_wdata_in[7:6]) == 2'h0)) else $error("switch mode decode");
    primary_mode_a: assert property (wr_at(ADDR_OSC_MODE) |=>
        primary_osc_mode_out == $past(cfg_wdata_in[1:0])) else $error("primary mode decode");
    wd_window_a: assert property (wr_at(ADDR_WATCHDOG) |=>
        watchdog_window_out == !$past(cfg_wdata_in[6])) else $error("window decode");
    wd_prescale_a: assert property (wr_at(ADDR_WATCHDOG) |=>
        watchdog_pre_log2_out == ($past(cfg_wdata_in[4]) ? 4'h7 : 4'h5)) else $error("prescale");
    wd_post_a: assert property (wr_at(ADDR_WATCHDOG) |=>
        watchdog_post_log2_out == $past(cfg_wdata_in[3:0])) else $error("postscale decode");
    powerup_timer_sel_a: assert property (wr_at(ADDR_POWER_ON) |=> powerup_delay_ms_out ==
        ($past(cfg_wdata_in[2:0]) == 3'h0 ? 8'h00 : 8'h01 << $past(cfg_wdata_in[2:0])))
        else $error("power-up delay decode");
    debug_sel_a: assert property (wr_at(ADDR_DEBUG) |=>
        boundary_scan_enable_out == $past(cfg_wdata_in[5])
        && debug_pair_out == ~$past(cfg_wdata_in[1:0])) else $error("debug decode");
    bor_flag_a: assert property (bor_rise |-> ##[1:3]
        (brownout_flag_out && core_reset_out)) else $error("brown-out not flagged");
    reg_hold_a: assert property (pu_rise |-> ##[2:4] exec_hold_out [*4])
        else $error("regulator hold missing");
    clk_hold_a: assert property (sysclk_hold_out |-> core_reset_out)
        else $error("clock held while core runs");
endmodule
bind config_decode_reset_seq config_decode_reset_seq_chk #(
    .US_CYCLES(US_CYCLES),
    .LARGE_PART(LARGE_PART)
) i_chk (.*);
`default_nettype wire

// file: config_decode_reset_seq_bench.sv
// self-checking bench for the configuration decoder and reset sequencer
// assumes cfgdec_pkg, the design and its checker are compiled first
`timescale 1ns/100ps
`default_nettype none
module config_decode_reset_seq_bench;
    import cfgdec_pkg::*;
    localparam int USC = 4;
    logic core_clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic [23:0] cfg_addr_in = 24'h0;
    logic cfg_rd_in = 1'b0, cfg_wr_in = 1'b0;
    logic [7:0] cfg_wdata_in = 8'h0;
    logic [23:0] boot_end_in = 24'h0007fe;
    logic [12:0] boot_ram_bytes_in = 13'h0080;
    logic power_up_in = 1'b0, brownout_in = 1'b0, osc_ready_in = 1'b1, pll_lock_in = 1'b0;
    logic watchdog_soft_enable_in = 1'b0, bor_flag_clear_in = 1'b0, switch_req_in = 1'b0;
    logic [2:0] switch_target_in = 3'h0;
    logic [7:0] cfg_rdata_out, powerup_delay_ms_out;
    logic core_reset_out, exec_hold_out, sysclk_hold_out, brownout_flag_out, switch_go_out;
    logic secure_present_out, secure_high_out, secure_write_block_out, general_protect_out;
    logic general_high_out, general_write_lock_out, clock_switch_en_out, failsafe_en_out;
    logic osc_pin_clock_out, watchdog_run_out, watchdog_window_out, boundary_scan_enable_out;
    logic [23:0] secure_start_out, secure_end_out, general_start_out;
    logic [12:0] secure_ram_bytes_out;
    logic [2:0] active_osc_out, initial_osc_sel_out;
    logic [1:0] primary_osc_mode_out, debug_pair_out;
    logic [3:0] watchdog_pre_log2_out, watchdog_post_log2_out;
    int n_mismatch = 0, total_checks = 0, cyc = 0;
    config_decode_reset_seq #(.US_CYCLES(USC), .LARGE_PART(1'b1)) i_dut (.*);
    always #2.5 core_clk_in = ~core_clk_in;
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // a hang is cut short well beyond the longest sequence
    always @(posedge core_clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            close_out();
        end
    end
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            $display("[ERR] %s expected %0h seen %0h", nm, e, g);
            n_mismatch++;
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(negedge core_clk_in);
    endtask
    task automatic wr(logic [23:0] a, logic [7:0] d);
        cfg_addr_in = a;
        cfg_wdata_in = d;
        cfg_wr_in = 1'b1;
        tick(1);
        cfg_wr_in = 1'b0;
        tick(1);
    endtask
    task automatic rd(logic [23:0] a, logic [7:0] e);
        cfg_addr_in = a;
        cfg_rd_in = 1'b1;
        tick(1);
        cfg_rd_in = 1'b0;
        chk("rdata", e, cfg_rdata_out);
        tick(1);
    endtask
    task automatic wait_rel(int lim, output int n);
        n = 0;
        while (core_reset_out !== 1'b0 && n < lim) begin
            tick(1);
            n++;
        end
    endtask
    task automatic t_erased();
        logic [23:0] ad [8];
        logic [7:0] mk [8];
        ad = '{ADDR_SECURE, ADDR_GENERAL, ADDR_OSC_SEL, ADDR_OSC_MODE, ADDR_WATCHDOG,
            ADDR_POWER_ON, ADDR_DEBUG, 24'hf80010};
        mk = '{8'hcf, 8'h07, 8'h87, 8'hc7, 8'hff, 8'h07, 8'he3, 8'h00};
        for (int i = 0; i < 8; i++) begin
            rd(ad[i], mk[i]);
        end
        chk("powerup_timer_ms", 128, powerup_delay_ms_out);
    endtask
    task automatic t_secure();
        logic [23:0] e;
        for (int i = 0; i < 8; i++) begin
            wr(ADDR_SECURE, {i[1:0], 2'h0, i[2:0], i[0]});
            e = (i[1:0] == 2'h3) ? 24'h0007fe : (i[1:0] == 2'h2) ? 24'h003ffe :
                (i[1:0] == 2'h1) ? 24'h007ffe : 24'h00fffe;
            chk("sec_on", i[1:0] != 2'h3, secure_present_out);
            chk("sec_end", e, secure_end_out);
            chk("sec_start", 24'h000800, secure_start_out);
            chk("sec_wp", !i[0], secure_write_block_out);
            chk("gen_start", e + 24'h2, general_start_out);
            if (i[1:0] != 2'h3) chk("sec_high", !i[2], secure_high_out);
            e = (i[1:0] == 2'h3) ? 0 : (i[1:0] == 2'h2) ? 128 : (i[1:0] == 2'h1) ? 1920 : 3968;
            chk("sec_ram", e, secure_ram_bytes_out);
        end
        for (int j = 0; j < 4; j++) begin
            wr(ADDR_GENERAL, {5'h0, j[1:0], j[0]});
            chk("gen_prot", j != 3, general_protect_out);
            if (j != 3) chk("gen_high", !j[1], general_high_out);
            chk("gen_lock", !j[0], general_write_lock_out);
        end
    endtask
    task automatic t_clock();
        wr(ADDR_POWER_ON, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_OSC_MODE, {i[1:0], 3'h0, i[0], i[1:0]});
            chk("pin_clk", i == 3, osc_pin_clock_out);
        end
        for (int c = 0; c < 8; c++) begin
            wr(ADDR_OSC_SEL, {5'h0, c[2:0]});
            chk("osc_sel", c, initial_osc_sel_out);
            chk("osc_run", c == 6 ? 0 : c, active_osc_out);
        end
        wr(ADDR_OSC_MODE, 8'h43);
        tick(30);
        chk("run", 0, core_reset_out);
        wr(ADDR_OSC_SEL, {5'h0, OSC_PRI});
        chk("osc_kept", OSC_FRC_DIV, active_osc_out);
        wr(ADDR_OSC_MODE, 8'hc3);
        chk("osc_now", OSC_PRI, active_osc_out);
    endtask
    task automatic t_dog();
        for (int i = 0; i < 16; i++) begin
            watchdog_soft_enable_in = i[3];
            wr(ADDR_WATCHDOG, {i[2], i[1], 1'b0, i[0], i[3:0]});
            chk("wd_run", i[2] | i[3], watchdog_run_out);
        end
        for (int i = 0; i < 8; i++) begin
            wr(ADDR_POWER_ON, {5'h0, i[2:0]});
            wr(ADDR_DEBUG, {2'h3, i[2], 3'h0, i[1:0]});
            chk("scan_en", i[2], boundary_scan_enable_out);
        end
    endtask
    task automatic t_brownout();
        int n;
        wr(ADDR_POWER_ON, 8'h00);
        wr(ADDR_OSC_MODE, 8'h41);
        wr(ADDR_OSC_SEL, 8'h82);
        osc_ready_in = 1'b0;
        brownout_in = 1'b1;
        tick(5);
        brownout_in = 1'b0;
        chk("bor_flag", 1, brownout_flag_out);
        tick(500);
        chk("rst_held", 1, core_reset_out);
        chk("clk_held", 1, sysclk_hold_out);
        chk("fast_rc", OSC_FRC, active_osc_out);
        osc_ready_in = 1'b1;
        wait_rel(20, n);
        chk("release", 1, n < 20);
        chk("osc_bor", OSC_PRI, active_osc_out);
        brownout_in = 1'b1;
        tick(5);
        brownout_in = 1'b0;
        tick(380);
        chk("fs_delay", 1, core_reset_out);
        wait_rel(60, n);
        chk("fs_end", 1, n < 60);
        bor_flag_clear_in = 1'b1;
        tick(1);
        bor_flag_clear_in = 1'b0;
        tick(1);
        chk("bor_clr", 0, brownout_flag_out);
    endtask
    task automatic t_switch();
        wr(ADDR_WATCHDOG, 8'h20);
        switch_target_in = OSC_PRI_PLL;
        switch_req_in = 1'b1;
        tick(4);
        chk("sw_wait", 0, switch_go_out);
        pll_lock_in = 1'b1;
        tick(4);
        chk("sw_lock", 1, switch_go_out);
        pll_lock_in = 1'b0;
        wr(ADDR_WATCHDOG, 8'h00);
        tick(4);
        chk("sw_nowait", 1, switch_go_out);
        switch_req_in = 1'b0;
    endtask
    task automatic t_powerup();
        int n;
        power_up_in = 1'b1;
        n = 0;
        tick(5);
        while (exec_hold_out === 1'b1 && n < 200) begin
            tick(1);
            n++;
        end
        chk("reg_hold", 1, n >= 20 * USC - 6 && n <= 20 * USC + 2);
        power_up_in = 1'b0;
    endtask
    initial begin
        tick(8);
        reset_in = 1'b0;
        tick(1);
        t_erased();
        t_secure();
        t_clock();
        t_dog();
        t_brownout();
        t_switch();
        t_powerup();
        close_out();
    end
endmodule
`default_nettype wire
